// ### pkg/cdbrm_pkg.sv
// constants shared by the receive mailbox and its frame fifo
`default_nettype none
package cdbrm_pkg;
    // ----------------
    // frame layout
    // ----------------
    localparam int ID_W        = 29;   // extended arbitration identifier
    localparam int DLC_W       = 4;    // data length code
    localparam int NUM_BYTES   = 8;    // data bytes per frame
    localparam int DATA_W      = 64;   // NUM_BYTES * 8
    localparam int FRAME_W     = 97;   // ID_W + DLC_W + DATA_W
    localparam int FIFO_DEPTH  = 16;   // frame records held ahead of the mailbox
    localparam int IDX_W       = 3;    // index of a data byte

    // field positions inside a frame record
    localparam int FR_DATA_LSB = 0;
    localparam int FR_DLC_LSB  = 64;
    localparam int FR_ID_LSB   = 68;

    // ----------------
    // host read map of the presented buffer
    // ----------------
    localparam logic [3:0] RA_ARB0  = 4'h0;  // arbitration bytes 0..3
    localparam logic [3:0] RA_ARB3  = 4'h3;
    localparam logic [3:0] RA_CFG   = 4'h4;  // dlc in bits 7:4
    localparam logic [3:0] RA_DATA0 = 4'h5;  // data bytes 0..7 at 5..12
    localparam logic [3:0] RA_DATA7 = 4'hc;

    // control-0 register of this mailbox and its message-valid field
    localparam logic [7:0] CTRL0_OFS    = 8'hf0;
    localparam int         MESSAGE_VALID_FIELD_LSB   = 6;
    localparam logic [1:0] MESSAGE_VALID_FIELD_SET   = 2'h2;
    localparam logic [1:0] MESSAGE_VALID_FIELD_RESET = 2'h1;

    // reset values
    localparam logic       FLAG_RST  = 1'h0;
    localparam logic       INT_N_RST = 1'h1;
    localparam logic [7:0] BYTE_RST  = 8'h00;

    // store engine states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COPY = 3'b010,
        ST_DONE = 3'b100
    } cdbrm_state_type;
endpackage
`default_nettype wire

// ### hdl/cdbrm_fifo.sv
// synchronous fifo of frame records with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cdbrm_fifo #(
    parameter int WIDTH = 97,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,   // system clock
    input  wire logic             sys_rst,   // synchronous reset, high
    input  wire logic             clk_en,    // freezes all state when low
    input  wire logic             in_valid,  // writer offers a word
    output logic                  in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] in_data,   // word written
    output logic                  out_valid, // a word is held
    input  wire logic             out_ready, // reader takes the word
    output logic      [WIDTH-1:0] out_data   // oldest word
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    wr_ptr_d;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW-1:0]    rd_ptr_d;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             push;
    logic             pop;

    // honest flags straight from the occupancy count
    assign in_ready  = (count_q != (PW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count next values
    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d  = count_q;
        if (push) begin
            wr_ptr_d = (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
        end
        case ({push, pop})
            2'b10:   count_d = count_q + 1'b1;
            2'b01:   count_d = count_q - 1'b1;
            default: count_d = count_q;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (clk_en) begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // storage needs no reset; only written words are ever read
    always_ff @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ### hdl/cdbrm_mailbox.sv
// double-buffered last receive mailbox: buffers, flags, host read path
//
// Behaviour
// - a read during a second store may return one byte of the new frame
// - in double-read mode that corrupted byte is latched into the holding register
// - second frame does not set pending-interrupt or new-data again
// - second frame while new-data set raises message-lost
// - second frame while new-data set raises remote-pending
// - third frame overwrites first buffer's identifier with its own
// - third frame leaves second buffer's identifier unchanged
// - after reset all four flags are 0 and interrupt line is 1
// - first frame sets new-data and pending-interrupt, drives interrupt low
// - clearing pending-interrupt after two frames releases line, others stay
// - after clears, new-data and pending-interrupt stay 0 while second is read
// - message-valid is two bits at top of control-0 at 0xf0
`timescale 1ns/1ps
`default_nettype none
module cdbrm_mailbox (
    input  wire logic                          sys_clk,          // 25 MHz system clock
    input  wire logic                          sys_rst,          // synchronous reset, high
    input  wire logic                          clk_en,           // freezes all state when low
    input  wire logic                          rx_valid,         // receive path offers a frame
    output logic                               rx_ready,         // fifo can take the frame
    input  wire logic [cdbrm_pkg::ID_W-1:0]    rx_id,            // received identifier
    input  wire logic [cdbrm_pkg::DLC_W-1:0]   rx_dlc,           // received length
    input  wire logic [cdbrm_pkg::DATA_W-1:0]  rx_data,          // byte 0 in bits 7:0
    input  wire logic [1:0]                    message_valid_field, // control-0 bits 7:6
    input  wire logic                          int_enable,       // mailbox interrupt enable
    input  wire logic                          clr_interrupt_pending, // host clear pulse
    input  wire logic                          clr_new_data,     // host clear pulse
    input  wire logic                          clr_remote_pending, // host clear pulse
    input  wire logic                          clr_message_lost, // host clear pulse
    input  wire logic                          rd_en,            // host read strobe
    input  wire logic [3:0]                    rd_addr,          // byte within mailbox
    input  wire logic                          dbl_read_mode,    // double-read access mode
    output logic      [7:0]                    rd_data,          // read byte, registered
    output logic                               interrupt_pending_flag, // pending interrupt
    output logic                               new_data_flag,    // unread data held
    output logic                               message_lost_flag, // frame overwritten
    output logic                               remote_pending_flag, // second frame held
    output logic                               front_buffer,     // buffer shown to host
    output logic                               store_busy,       // store engine working
    output logic                               int_n             // interrupt, active low
);
    import cdbrm_pkg::*;

    // ----------------
    // decoding shared by the read path and the corruption window
    // ----------------
    function automatic logic is_data_addr(input logic [3:0] a);
        return (a >= RA_DATA0) && (a <= RA_DATA7);
    endfunction

    function automatic logic [IDX_W-1:0] data_index(input logic [3:0] a);
        logic [3:0] off;
        off = a - RA_DATA0;
        return off[IDX_W-1:0];
    endfunction

    // ----------------
    // frame fifo in front of the store engine
    // ----------------
    logic               fifo_valid;
    logic               fifo_ready;
    logic [FRAME_W-1:0] fifo_frame;

    cdbrm_fifo #(
        .WIDTH (FRAME_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   ({rx_id, rx_dlc, rx_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_frame)
    );

    // ----------------
    // store engine: copies one data byte a cycle, then commits id and flags
    // ----------------
    cdbrm_state_type    state_q;
    cdbrm_state_type    state_d;
    logic [FRAME_W-1:0] cur_q;
    logic [FRAME_W-1:0] cur_d;
    logic               tgt_q;
    logic               tgt_d;
    logic [IDX_W-1:0]   idx_q;
    logic [IDX_W-1:0]   idx_d;
    logic               message_valid_field_on;
    logic [7:0]         cur_byte;

    // reception only while the message-valid field reads as set
    assign message_valid_field_on  = (message_valid_field == MESSAGE_VALID_FIELD_SET);
    // engine stalls the fifo while copying, so back-pressure reaches rx_ready
    assign fifo_ready = (state_q == ST_IDLE) && message_valid_field_on;
    assign cur_byte   = cur_q[FR_DATA_LSB + 8*idx_q +: 8];
    assign store_busy = (state_q != ST_IDLE);

    // flags, needed here to choose the target buffer
    logic new_q, new_d;
    logic ipnd_q, ipnd_d;
    logic lost_q, lost_d;
    logic rpnd_q, rpnd_d;
    logic two_q, two_d;
    logic front_q, front_d;
    logic fresh;
    logic second;
    logic commit;

    // fresh frame: nothing unread; otherwise second or overrun goes to buffer 1
    assign fresh  = !new_q && !rpnd_q;
    assign second = !fresh && !two_q;
    assign commit = (state_q == ST_DONE);

    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        tgt_d   = tgt_q;
        idx_d   = idx_q;
        unique case (state_q)
            ST_IDLE: begin
                if (fifo_valid && fifo_ready) begin
                    cur_d   = fifo_frame;
                    tgt_d   = !fresh;
                    idx_d   = '0;
                    state_d = ST_COPY;
                end
            end
            ST_COPY: begin
                idx_d = idx_q + 1'b1;
                if (idx_q == IDX_W'(NUM_BYTES-1)) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cur_q   <= '0;
            tgt_q   <= 1'b0;
            idx_q   <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            cur_q   <= cur_d;
            tgt_q   <= tgt_d;
            idx_q   <= idx_d;
        end
    end

    // ----------------
    // the two buffers
    // ----------------
    logic [ID_W-1:0]  id_q  [2];
    logic [DLC_W-1:0] dlc_q [2];
    logic [7:0]       dat_q [2][NUM_BYTES];

    for (genvar b = 0; b < 2; b++) begin : g_buf
        logic [ID_W-1:0]  id_d;
        logic [DLC_W-1:0] dlc_d;
        logic [7:0]       dat_d [NUM_BYTES];

        always_comb begin
            id_d  = id_q[b];
            dlc_d = dlc_q[b];
            dat_d = dat_q[b];
            if (state_q == ST_COPY && tgt_q == 1'(b)) begin
                dat_d[idx_q] = cur_byte;
            end
            if (commit) begin
                if (b == 0 && (fresh || (!second && tgt_q))) begin
                    // on overrun buffer 0 takes only the new identifier
                    id_d = cur_q[FR_ID_LSB +: ID_W];
                end
                if (tgt_q == 1'(b)) begin
                    dlc_d = cur_q[FR_DLC_LSB +: DLC_W];
                    if (b == 0 || second) begin
                        id_d = cur_q[FR_ID_LSB +: ID_W];
                    end
                end
            end
        end

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                id_q[b]  <= '0;
                dlc_q[b] <= '0;
                for (int i = 0; i < NUM_BYTES; i++) begin
                    dat_q[b][i] <= BYTE_RST;
                end
            end else if (clk_en) begin
                id_q[b]  <= id_d;
                dlc_q[b] <= dlc_d;
                dat_q[b] <= dat_d;
            end
        end
    end

    // ----------------
    // flags and interrupt line
    // ----------------
    // hardware set wins over a host clear in the same cycle
    always_comb begin
        new_d   = new_q;
        ipnd_d  = ipnd_q;
        lost_d  = lost_q;
        rpnd_d  = rpnd_q;
        two_d   = two_q;
        front_d = front_q;
        if (clr_new_data) begin
            new_d = 1'b0;
            if (two_q) begin
                front_d = 1'b1;        // host moves on to the second frame
            end
        end
        if (clr_interrupt_pending) begin
            ipnd_d = 1'b0;
        end
        if (clr_message_lost) begin
            lost_d = 1'b0;
        end
        if (clr_remote_pending) begin
            rpnd_d = 1'b0;
        end
        if (commit) begin
            if (fresh) begin
                new_d   = 1'b1;
                ipnd_d  = 1'b1;
                two_d   = 1'b0;
                front_d = 1'b0;
            end else begin
                // second or later frame never re-arms these two
                lost_d = 1'b1;
                rpnd_d = 1'b1;
                two_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            new_q   <= FLAG_RST;
            ipnd_q  <= FLAG_RST;
            lost_q  <= FLAG_RST;
            rpnd_q  <= FLAG_RST;
            two_q   <= FLAG_RST;
            front_q <= 1'b0;
        end else if (clk_en) begin
            new_q   <= new_d;
            ipnd_q  <= ipnd_d;
            lost_q  <= lost_d;
            rpnd_q  <= rpnd_d;
            two_q   <= two_d;
            front_q <= front_d;
        end
    end

    assign interrupt_pending_flag = ipnd_q;
    assign new_data_flag          = new_q;
    assign message_lost_flag      = lost_q;
    assign remote_pending_flag    = rpnd_q;
    assign front_buffer           = front_q;

    // registered so the line never glitches while flags settle
    logic int_n_q, int_n_d;
    assign int_n_d = !(ipnd_d && int_enable);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_n_q <= INT_N_RST;
        end else if (clk_en) begin
            int_n_q <= int_n_d;
        end
    end

    assign int_n = int_n_q;

    // ----------------
    // host read path
    // ----------------
    logic [31:0] arb_word;
    logic [7:0]  sel_byte;
    logic [7:0]  rd_q, rd_d;
    logic [7:0]  hold_q, hold_d;

    assign arb_word = {id_q[front_q], 3'h0};

    // the byte lane is shared with the store path, hence the corruption window
    always_comb begin
        sel_byte = BYTE_RST;
        if (rd_addr <= RA_ARB3) begin
            sel_byte = arb_word[8*(RA_ARB3 - rd_addr) +: 8];
        end else if (rd_addr == RA_CFG) begin
            sel_byte = {dlc_q[front_q], 4'h0};
        end else if (is_data_addr(rd_addr)) begin
            sel_byte = dat_q[front_q][data_index(rd_addr)];
            if (state_q == ST_COPY && data_index(rd_addr) == idx_q) begin
                sel_byte = cur_byte;
            end
        end
    end

    // double-read: the access latches the holding register, and the byte
    // returned is the one latched by the previous access
    always_comb begin
        rd_d   = rd_q;
        hold_d = hold_q;
        if (rd_en) begin
            if (dbl_read_mode) begin
                hold_d = sel_byte;
                rd_d   = hold_q;
            end else begin
                rd_d = sel_byte;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_q   <= BYTE_RST;
            hold_q <= BYTE_RST;
        end else if (clk_en) begin
            rd_q   <= rd_d;
            hold_q <= hold_d;
        end
    end

    assign rd_data = rd_q;
endmodule
`default_nettype wire

// ### dv/cdbrm_mailbox_assertions.sv
// assertions on the receive mailbox ports
`timescale 1ns/1ps
`default_nettype none
module cdbrm_mailbox_assertions (
    input wire logic sys_clk,                // clock
    input wire logic sys_rst,                // reset
    input wire logic clk_en,                 // run
    input wire logic int_enable,             // irq enable
    input wire logic clr_interrupt_pending,  // clear
    input wire logic clr_new_data,           // clear
    input wire logic interrupt_pending_flag, // flag
    input wire logic new_data_flag,          // flag
    input wire logic message_lost_flag,      // flag
    input wire logic remote_pending_flag,    // flag
    input wire logic store_busy,             // engine busy
    input wire logic int_n                   // irq line
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // no disable here: reset wins even over a commit edge
    chk_reset_clean: assert property (disable iff (1'h0)
        sys_rst |=> int_n && !interrupt_pending_flag && !new_data_flag
            && !message_lost_flag && !remote_pending_flag)
        else $error("flags not clear after reset");
    chk_line_follows: assert property ($past(clk_en) |->
        int_n == !(interrupt_pending_flag && $past(int_enable)))
        else $error("interrupt line wrong");
    chk_second_quiet: assert property ($rose(remote_pending_flag) |->
        !$rose(new_data_flag) && !$rose(interrupt_pending_flag))
        else $error("second frame raised pending or new data");
    chk_lost_cause: assert property ($rose(message_lost_flag) |->
        $past(new_data_flag || remote_pending_flag) && $past(store_busy))
        else $error("lost flag without held frame");
    chk_remote_lost: assert property ($rose(remote_pending_flag) |->
        message_lost_flag && $past(new_data_flag || remote_pending_flag))
        else $error("remote flag without lost flag");
    chk_fresh_frame: assert property ($rose(new_data_flag) |->
        interrupt_pending_flag && !remote_pending_flag && !$rose(message_lost_flag))
        else $error("first frame flags wrong");
    // flags may only rise at the commit edge, which ends a busy cycle
    chk_commit_only: assert property (!store_busy |=>
        !$rose(new_data_flag) && !$rose(interrupt_pending_flag))
        else $error("flag rose outside commit");
    chk_clear_pend: assert property (
        clr_interrupt_pending && clk_en && !store_busy |=> !interrupt_pending_flag && int_n)
        else $error("pending clear ignored");
    chk_clear_data: assert property (
        clr_new_data && clk_en && !store_busy |=> !new_data_flag)
        else $error("new data clear ignored");
    // eight copy cycles then one commit cycle, clock enable held high
    chk_store_span: assert property ($rose(store_busy) |->
        store_busy[*8] ##1 store_busy ##1 !store_busy)
        else $error("store length wrong");
    cov_fresh: cover property ($rose(new_data_flag));
    cov_second: cover property ($rose(remote_pending_flag));
    cov_clear: cover property ($fell(interrupt_pending_flag));
endmodule
`default_nettype wire

// ### dv/cdbrm_host_model.sv
// host processor model: flag clears, byte reads, reception control
`timescale 1ns/1ps
`default_nettype none
module cdbrm_host_model (
    input  wire logic       sys_clk,               // clock
    input  wire logic [7:0] rd_data,               // byte returned
    output logic            clr_interrupt_pending, // clear pulse
    output logic            clr_new_data,          // clear pulse
    output logic            clr_remote_pending,    // clear pulse
    output logic            clr_message_lost,      // clear pulse
    output logic            rd_en,                 // read strobe
    output logic      [3:0] rd_addr,               // byte select
    output logic            dbl_read_mode,         // double read
    output logic      [1:0] message_valid_field    // reception enable
);
    import cdbrm_pkg::*;
    logic [3:0] clr_q; // lost, remote, new, pending
    assign {clr_message_lost, clr_remote_pending, clr_new_data, clr_interrupt_pending} = clr_q;
    // idle host with reception on
    initial begin
        clr_q = 4'h0;
        rd_en = 1'h0;
        rd_addr = 4'h0;
        dbl_read_mode = 1'h0;
        message_valid_field = MESSAGE_VALID_FIELD_SET;
    end
    // one pulse on each clear in the mask
    task automatic clear(input logic [3:0] mask);
        @(posedge sys_clk);
        clr_q <= mask;
        @(posedge sys_clk);
        clr_q <= 4'h0;
        #1;
    endtask
    // byte shows after the taking edge, so it is sampled just past it
    task automatic read(input logic [3:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        rd_en   <= 1'h1;
        rd_addr <= addr;
        @(posedge sys_clk);
        rd_en <= 1'h0;
        #1;
        data = rd_data;
    endtask
    // a stalled field keeps frames waiting in the fifo
    task automatic setup(input logic [1:0] v, input logic dbl);
        @(posedge sys_clk);
        message_valid_field <= v;
        dbl_read_mode       <= dbl;
        #1;
    endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench of the double-buffered receive mailbox
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cdbrm_pkg::*;
    logic              sys_clk    = 1'h0;
    logic              sys_rst    = 1'h1;
    logic              clk_en     = 1'h1;
    logic              rx_valid   = 1'h0;
    logic              int_enable = 1'h1;
    logic [ID_W-1:0]   rx_id      = 29'h0;
    logic [DLC_W-1:0]  rx_dlc     = 4'h0;
    logic [DATA_W-1:0] rx_data    = 64'h0;
    logic [7:0]        rd_data;
    logic [3:0]        rd_addr;
    logic [1:0]        message_valid_field;
    logic              rx_ready, store_busy, front_buffer, int_n, rd_en, dbl_read_mode;
    logic              clr_interrupt_pending, clr_new_data, clr_remote_pending;
    logic              clr_message_lost, interrupt_pending_flag, new_data_flag;
    logic              message_lost_flag, remote_pending_flag;
    int                failures     = 0;
    int                total_checks = 0;

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    cdbrm_mailbox cdbrm_mailbox_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .message_valid_field(message_valid_field), .int_enable(int_enable),
        .clr_interrupt_pending(clr_interrupt_pending), .clr_new_data(clr_new_data),
        .clr_remote_pending(clr_remote_pending), .clr_message_lost(clr_message_lost),
        .rd_en(rd_en), .rd_addr(rd_addr), .dbl_read_mode(dbl_read_mode), .rd_data(rd_data),
        .interrupt_pending_flag(interrupt_pending_flag), .new_data_flag(new_data_flag),
        .message_lost_flag(message_lost_flag), .remote_pending_flag(remote_pending_flag),
        .front_buffer(front_buffer), .store_busy(store_busy), .int_n(int_n));
    cdbrm_host_model cdbrm_host_model_inst (
        .sys_clk(sys_clk), .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .clr_interrupt_pending(clr_interrupt_pending), .clr_new_data(clr_new_data),
        .clr_remote_pending(clr_remote_pending), .clr_message_lost(clr_message_lost),
        .dbl_read_mode(dbl_read_mode), .message_valid_field(message_valid_field));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // order: remote, new data, lost, pending, line
    task automatic flags(input logic [4:0] exp);
        check("flags", {3'h0, exp}, {3'h0, remote_pending_flag, new_data_flag,
            message_lost_flag, interrupt_pending_flag, int_n});
    endtask
    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        cdbrm_host_model_inst.read(a, d);
        check(what, exp, d);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // frame k of the set: 1 and 2 distinct, all later ones alike
    task automatic send(input int k);
        int n;
        @(posedge sys_clk);
        rx_valid <= 1'h1;
        rx_id    <= (k == 1) ? 29'h111 : (k == 2) ? 29'h222 : 29'h333;
        rx_dlc   <= (k == 1) ? 4'h4 : (k == 2) ? 4'h5 : 4'h6;
        rx_data  <= (k == 1) ? 64'h03020100 : (k == 2) ? 64'h0807060504 : 64'h0e0d0c0b0a09;
        for (n = 0; n < 300 && rx_ready !== 1'h1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 300) begin
            failures++;
            complete_run();
        end
        @(posedge sys_clk);
        rx_valid <= 1'h0;
        #1;
    endtask

    task automatic test_reset;
        flags(5'h01);
        check("ready", 8'h01, {7'h0, rx_ready});
        $display("test reset done");
    endtask
    // second frame lands while the first is still being read
    task automatic test_two_frames;
        logic [7:0] d;
        int         n;
        send(1);
        settle(12);
        flags(5'h0a);
        @(posedge sys_clk);
        int_enable <= 1'h0;
        settle(1);
        check("masked line", 8'h01, {7'h0, int_n});
        int_enable <= 1'h1;
        settle(1);
        flags(5'h0a);
        rd("first id", 4'h3, 8'h88);
        cdbrm_host_model_inst.setup(MESSAGE_VALID_FIELD_SET, 1'h1);
        cdbrm_host_model_inst.read(4'h8, d);
        send(2);
        for (n = 0; n < 20 && store_busy !== 1'h1; n++) begin
            settle(1);
        end
        if (n == 20) begin
            failures++;
            complete_run();
        end
        rd("held byte", 4'h6, 8'h03);
        rd("raced byte", 4'h5, 8'h05);
        cdbrm_host_model_inst.setup(MESSAGE_VALID_FIELD_SET, 1'h0);
        settle(12);
        flags(5'h1e);
        cdbrm_host_model_inst.clear(4'h1);
        flags(5'h1d);
        cdbrm_host_model_inst.clear(4'h4);
        flags(5'h0d);
        cdbrm_host_model_inst.clear(4'h2);
        rd("second id", 4'h3, 8'h10);
        check("front", 8'h01, {7'h0, front_buffer});
        flags(5'h05);
        cdbrm_host_model_inst.clear(4'h8);
        flags(5'h01);
        $display("test two_frames done");
    endtask
    // fifo filled while reception is stalled, then drained in one burst
    task automatic test_overrun;
        cdbrm_host_model_inst.setup(MESSAGE_VALID_FIELD_RESET, 1'h0);
        for (int k = 1; k <= FIFO_DEPTH; k++) begin
            send(k);
        end
        check("full ready", 8'h00, {7'h0, rx_ready});
        check("stalled", 8'h00, {7'h0, store_busy});
        cdbrm_host_model_inst.setup(MESSAGE_VALID_FIELD_SET, 1'h0);
        settle(200);
        check("drained", 8'h01, {7'h0, rx_ready});
        flags(5'h1e);
        rd("first id", 4'h3, 8'h98);
        rd("first data", 4'h5, 8'h00);
        cdbrm_host_model_inst.clear(4'h7);
        rd("second id", 4'h3, 8'h10);
        rd("last dlc", 4'h4, 8'h60);
        rd("last data", 4'h5, 8'h09);
        $display("test overrun done");
    endtask

    // reset for twelve cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'h0;
        #1;
        test_reset();
        test_two_frames();
        test_overrun();
        complete_run();
    end
endmodule
bind cdbrm_mailbox cdbrm_mailbox_assertions cdbrm_mailbox_assertions_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .int_enable(int_enable),
    .clr_interrupt_pending(clr_interrupt_pending), .clr_new_data(clr_new_data),
    .interrupt_pending_flag(interrupt_pending_flag), .new_data_flag(new_data_flag),
    .message_lost_flag(message_lost_flag), .remote_pending_flag(remote_pending_flag),
    .store_busy(store_busy), .int_n(int_n));
`default_nettype wire
